// [tb/cirb_host_model.sv]
// Partner: serial control port host
`timescale 1ns/1ns
module cirb_host_model (
	input  wire logic clk_in,
	input  wire logic miso_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      mosi_out
);
	// Clock idles low, select idles high
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic xfer(input logic rd, input logic [9:0] a, input logic [7:0] d, input logic lsb,
		output logic [7:0] q);
		logic [23:0] w;
		int          b;
		w = {rd, 5'h00, a, d};
		q = 8'h00;
		@(posedge clk_in) cs_n_out <= 1'b0;
		idle(4);
		for (int i = 0; i < 24; i++) begin
			b = lsb ? (i < 16 ? i + 8 : i - 16) : 23 - i;
			// Released line toggles so a stale bit never passes
			mosi_out <= (rd && i > 15) ? ~mosi_out : w[b];
			idle(7);
			sclk_out <= 1'b1;
			idle(7);
			if (i > 15) q[b] = miso_in;
			sclk_out <= 1'b0;
		end
		idle(7);
		cs_n_out <= 1'b1;
		idle(6);
	endtask
endmodule

// [tb/tb_top.sv]
// Testbench: host frames against the config bank
`timescale 1ns/1ns
module tb_top
	import cirb_pkg::*;
;
	logic        clk = 1'b0, rst_n = 1'b0, got_v = 1'b0, ce = 1'b1, fw = 1'b1;
	logic        sclk, cs_n, mosi, miso, sdio_w, sdio_o, sdio_oe, sdo, sdo_oe;
	logic [1:0]  pwr;
	logic [15:0] freq, f;
	logic [7:0]  got, r;
	logic [15:0] exp_q[$];
	int          err_count = 0, n_compared = 0;
	logic [9:0]  ofs_t[14] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h005, 10'h006, 10'h00C,
		10'h00D, 10'h100, 10'h101, 10'h2BC, 10'h2DC, 10'h343};
	logic [7:0]  rst_t[14] = '{8'h18, 8'h00, 8'h00, 8'h5A, 8'h34, 8'h12, 8'h21, 8'h9C, 8'h7E, 8'h10,
		8'h0E, 8'h80, 8'h80, 8'h00};
	// Pin resolves from the drive enables
	assign sdio_w = sdio_oe ? sdio_o : mosi;
	// Host reads the pin of the expected mode; an undriven pin shows the inverse
	assign miso   = fw ? (sdo_oe ? sdo : ~sdo) : (sdio_oe ? sdio_o : ~sdio_o);
	initial forever #25 clk = ~clk;
	cirb_config_id_bank uut (.CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce), .SCLK_IN(sclk),
		.CS_N_IN(cs_n), .SDIO_IN(sdio_w), .SDIO_OUT(sdio_o), .SDIO_OE_OUT(sdio_oe), .SDO_OUT(sdo),
		.SDO_OE_OUT(sdo_oe), .POWER_MODE_OUT(pwr), .CONV_CLK_FREQ_OUT(freq));
	cirb_host_model host (.clk_in(clk), .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
	task automatic check(input logic [15:0] seen, input logic [15:0] e);
		n_compared++;
		if (seen !== e) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, e);
		end
	endtask
	// Read frame; expectation goes in the queue
	task automatic rd(input logic [9:0] a, input logic l, input logic [7:0] e);
		host.xfer(1'b1, a, 8'h00, l, r);
		exp_q.push_back({8'h00, e});
		got <= r;
		got_v <= 1'b1;
		@(posedge clk) got_v <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic l);
		host.xfer(1'b0, a, d, l, r);
	endtask
	task automatic summarize();
		$display("Counts: compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Watcher: oldest note against each read result
	always @(posedge clk) begin
		if (got_v === 1'b1 && exp_q.size() > 0) check({8'h00, got}, exp_q.pop_front());
	end
	// Hang guard
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		summarize();
	end
	initial begin
		void'($urandom(69458));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		host.idle(4);
		for (int i = 0; i < 14; i++) rd(ofs_t[i], 1'b0, rst_t[i]);
		check(freq, 16'h0E10);
		$display("Test reset values done");
		repeat (3) begin
			f = 16'($urandom);
			wr(OFS_FREQ_LO, f[7:0], 1'b0);
			wr(OFS_FREQ_HI, f[15:8], 1'b0);
			check(freq, f);
			rd(OFS_FREQ_HI, 1'b0, f[15:8]);
		end
		// Clock enable low freezes the bank: the whole frame is lost
		ce <= 1'b0;
		wr(OFS_FREQ_LO, ~f[7:0], 1'b0);
		ce <= 1'b1;
		check(freq, f);
		wr(OFS_CLASS, 8'($urandom), 1'b0);
		rd(OFS_CLASS, 1'b0, 8'h5A);
		$display("Test frequency and read-only done");
		for (int c = 0; c < 4; c++) begin
			wr(OFS_POWER, {6'h3F, 2'(c)}, 1'b0);
			check({14'h0, pwr}, c == 1 ? 16'h0 : 16'(c));
			rd(OFS_POWER, 1'b0, {6'h00, 2'(c)});
		end
		$display("Test power states done");
		wr(OFS_FORMAT, 8'h42, 1'b0);
		fw = 1'b0;
		rd(OFS_FORMAT, 1'b1, 8'h42);
		rd(OFS_CODE_LO, 1'b1, 8'h34);
		wr(OFS_SHUF_TH_B, 8'h01, 1'b1);
		rd(OFS_SHUF_TH_B, 1'b1, 8'h01);
		$display("Test bit order done");
		wr(OFS_FORMAT, 8'h01, 1'b1);
		fw = 1'b1;
		rd(OFS_FORMAT, 1'b0, 8'h18);
		rd(OFS_SHUF_TH_B, 1'b0, 8'h00);
		check({14'h0, pwr}, 16'h0);
		check(freq, 16'h0E10);
		$display("Test soft reset done");
		summarize();
	end
endmodule

// [verilog/cirb_config_id_bank.sv]
// Top: serial control port engine of the configuration and identification bank
//
// Overview of operation
// - Writing reset bit restores defaults, self-clears
// - Bit order flag shifts both directions LSB-first
// - Four-wire flag sends reads on output pin
// - Low format bits mirror the high ones
// - Power field: normal, standby, sleep; 01 unused
// - Read-only eight-bit device class code
// - Read-only device code, low byte first
// - Read-only revision high nibble, grade low
// - Read-only maker code in two bytes
// - Sixteen-bit converter clock setting, 1 MHz units
//
// Frame: chip select low, 16-bit instruction (read flag at the top, offset
// in the low bits), then one data byte. Extra clocks are ignored.
`timescale 1ns/1ns
module cirb_config_id_bank
	import cirb_pkg::*;
#(
	parameter logic [DATA_W-1:0] DEVICE_CLASS = 8'h5A,    // Arbitrary value
	parameter logic [FREQ_W-1:0] DEVICE_CODE  = 16'h1234, // Arbitrary value
	parameter logic [3:0]        SILICON_REV  = 4'h2,     // Arbitrary value
	parameter logic [3:0]        SPEED_GRADE  = 4'h1,     // Arbitrary value
	parameter logic [FREQ_W-1:0] MAKER_CODE   = 16'h7E9C  // Arbitrary value
) (
	input  wire logic              CLK_IN,
	input  wire logic              RESET_N_IN,
	input  wire logic              CE_IN,
	input  wire logic              SCLK_IN,
	input  wire logic              CS_N_IN,
	input  wire logic              SDIO_IN,
	output logic                   SDIO_OUT,
	output logic                   SDIO_OE_OUT,
	output logic                   SDO_OUT,
	output logic                   SDO_OE_OUT,
	output logic [PWR_W-1:0]       POWER_MODE_OUT,
	output logic [FREQ_W-1:0]      CONV_CLK_FREQ_OUT
);
	// Frame phases
	typedef enum logic [1:0] {
		ST_INSTR,
		ST_DATA,
		ST_DONE
	} cirb_frame_e;

	cirb_reg_if rif ();

	logic [2:0]         pins_s;         // Synchronised pins
	logic               sclk_s;         // Serial clock, synchronised
	logic               cs_n_s;         // Chip select, synchronised
	logic               sdio_s;         // Serial data in, synchronised
	logic               rise;           // Serial clock rising
	logic               fall;           // Serial clock falling
	logic [INSTR_W-1:0] shifted;        // Shifter with the new bit
	cirb_frame_e        state;          // Frame phase
	cirb_frame_e        next_state;
	logic [CNT_W-1:0]   cnt;            // Bits taken in this phase
	logic [CNT_W-1:0]   next_cnt;
	logic [INSTR_W-1:0] sr;             // Receive shifter
	logic [INSTR_W-1:0] next_sr;
	logic               is_read;        // Frame is a read
	logic               next_is_read;
	logic [ADDR_W-1:0]  addr;           // Latched offset
	logic [ADDR_W-1:0]  next_addr;
	logic [DATA_W-1:0]  wdata;          // Received byte
	logic [DATA_W-1:0]  next_wdata;
	logic               wr;             // Write strobe
	logic               next_wr;
	logic               rd;             // Read strobe
	logic               next_rd;
	logic [1:0]         load_pipe;      // Waits for the read byte
	logic [1:0]         next_load_pipe;
	logic [DATA_W-1:0]  osr;            // Transmit shifter
	logic [DATA_W-1:0]  next_osr;
	logic               sclk_q;         // Previous serial clock
	logic               next_sclk_q;
	logic               sdio_out;       // Three-wire read data
	logic               next_sdio_out;
	logic               sdio_oe;        // Three-wire drive
	logic               next_sdio_oe;
	logic               sdo_out;        // Four-wire read data
	logic               next_sdo_out;
	logic               sdo_oe;         // Four-wire drive
	logic               next_sdo_oe;

	// Shift one bit in, in either order
	function automatic logic [INSTR_W-1:0] shift_bit(input logic [INSTR_W-1:0] v,
		input logic b, input logic lsb);
		shift_bit = lsb ? {b, v[INSTR_W-1:1]} : {v[INSTR_W-2:0], b};
	endfunction

	// Mirror a byte so the transmitter always shifts from the top
	function automatic logic [DATA_W-1:0] bit_rev(input logic [DATA_W-1:0] v);
		for (int i = 0; i < DATA_W; i++) begin
			bit_rev[i] = v[DATA_W-1-i];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and storage
	cirb_pin_sync #(
		.WIDTH   (3),
		.RST_VAL (SYNC_RESET)
	) u_sync (
		.clk_in   (CLK_IN),
		.rst_n_in (RESET_N_IN),
		.ce_in    (CE_IN),
		.async_in ({SCLK_IN, CS_N_IN, SDIO_IN}),
		.sync_out (pins_s)
	);

	cirb_reg_file #(
		.DEV_CLASS (DEVICE_CLASS),
		.DEV_CODE  (DEVICE_CODE),
		.REVISION  (SILICON_REV),
		.GRADE     (SPEED_GRADE),
		.MAKER     (MAKER_CODE)
	) u_regs (
		.clk_in   (CLK_IN),
		.rst_n_in (RESET_N_IN),
		.ce_in    (CE_IN),
		.rif      (rif.regs)
	);

	assign sclk_s = pins_s[2];
	assign cs_n_s = pins_s[1];
	assign sdio_s = pins_s[0];
	assign rise   = sclk_s && !sclk_q;
	assign fall   = !sclk_s && sclk_q;

	////////////////////////////////////////////////////////////////////////////
	// Frame engine, next values
	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_sr        = sr;
		next_is_read   = is_read;
		next_addr      = addr;
		next_wdata     = wdata;
		next_wr        = 1'b0;
		next_rd        = 1'b0;
		next_load_pipe = {load_pipe[0], 1'b0};
		next_osr       = osr;
		next_sclk_q    = sclk_s;
		next_sdio_out  = sdio_out;
		next_sdio_oe   = sdio_oe;
		next_sdo_out   = sdo_out;
		next_sdo_oe    = sdo_oe;
		shifted        = shift_bit(sr, sdio_s, rif.lsb_first);
		if (cs_n_s) begin
			// Deselected: abandon the frame, release both pins
			next_state     = ST_INSTR;
			next_cnt       = '0;
			next_load_pipe = '0;
			next_sdio_oe   = 1'b0;
			next_sdo_oe    = 1'b0;
			next_sdio_out  = 1'b0;
			next_sdo_out   = 1'b0;
		end else begin
			if (load_pipe[1]) begin
				next_osr = rif.lsb_first ? bit_rev(rif.rdata) : rif.rdata;
				next_sdo_oe  = rif.four_wire;
				next_sdio_oe = !rif.four_wire;
			end
			// Read data changes on the falling edge, host samples on rising
			if (fall && is_read && state != ST_INSTR) begin
				next_sdio_out = osr[DATA_W-1];
				next_sdo_out  = osr[DATA_W-1];
				next_osr      = {osr[DATA_W-2:0], 1'b0};
			end
			if (rise) begin
				unique case (state)
					ST_INSTR: begin
						next_sr  = shifted;
						next_cnt = cnt + 4'h1;
						if (cnt == INSTR_LAST) begin
							next_is_read      = shifted[RW_BIT];
							next_addr         = shifted[ADDR_W-1:0];
							next_rd           = shifted[RW_BIT];
							next_load_pipe[0] = shifted[RW_BIT];
							next_cnt          = '0;
							next_state        = ST_DATA;
						end
					end
					ST_DATA: begin
						next_sr  = shifted;
						next_cnt = cnt + 4'h1;
						if (cnt == DATA_LAST) begin
							next_state = ST_DONE;
							if (!is_read) begin
								next_wr    = 1'b1;
								next_wdata = rif.lsb_first ? shifted[INSTR_W-1 -: DATA_W] : shifted[DATA_W-1:0];
							end
						end
					end
					// Clocks beyond the byte are ignored until deselect
					ST_DONE: begin
						next_cnt = cnt;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame engine flops
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state     <= ST_INSTR;
			cnt       <= '0;
			sr        <= '0;
			is_read   <= 1'b0;
			addr      <= '0;
			wdata     <= '0;
			wr        <= 1'b0;
			rd        <= 1'b0;
			load_pipe <= '0;
			osr       <= '0;
			sclk_q    <= 1'b0;
			sdio_out  <= 1'b0;
			sdio_oe   <= 1'b0;
			sdo_out   <= 1'b0;
			sdo_oe    <= 1'b0;
		end else if (CE_IN) begin
			state     <= next_state;
			cnt       <= next_cnt;
			sr        <= next_sr;
			is_read   <= next_is_read;
			addr      <= next_addr;
			wdata     <= next_wdata;
			wr        <= next_wr;
			rd        <= next_rd;
			load_pipe <= next_load_pipe;
			osr       <= next_osr;
			sclk_q    <= next_sclk_q;
			sdio_out  <= next_sdio_out;
			sdio_oe   <= next_sdio_oe;
			sdo_out   <= next_sdo_out;
			sdo_oe    <= next_sdo_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all from flops
	assign rif.wr            = wr;
	assign rif.rd            = rd;
	assign rif.addr          = addr;
	assign rif.wdata         = wdata;
	assign SDIO_OUT          = sdio_out;
	assign SDIO_OE_OUT       = sdio_oe;
	assign SDO_OUT           = sdo_out;
	assign SDO_OE_OUT        = sdo_oe;
	assign POWER_MODE_OUT    = rif.power_mode;
	assign CONV_CLK_FREQ_OUT = rif.conv_freq;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_lsb_load;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		CE_IN && load_pipe[1] && !cs_n_s && !fall && rif.lsb_first |=> osr == bit_rev($past(rif.rdata));
	endproperty
	a_lsb_load: assert property (p_lsb_load) else $error("read byte not reversed");

	property p_pin_select;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		SDO_OE_OUT || SDIO_OE_OUT |-> SDO_OE_OUT == rif.four_wire && SDIO_OE_OUT != SDO_OE_OUT;
	endproperty
	a_pin_select: assert property (p_pin_select) else $error("read data on wrong pin");

	property p_mirror;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		CE_IN && rif.rd && rif.addr == OFS_FORMAT |=> rif.rdata[FMT_RST_LO] == rif.rdata[FMT_RST_HI]
		&& rif.rdata[FMT_LSB_LO] == rif.rdata[FMT_LSB_HI] && rif.rdata[FMT_4W_LO] == rif.rdata[FMT_4W_HI];
	endproperty
	a_mirror: assert property (p_mirror) else $error("format mirror mismatch");

	property p_class_ro;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		CE_IN && rif.rd && rif.addr == OFS_CLASS |=> rif.rdata == DEVICE_CLASS;
	endproperty
	a_class_ro: assert property (p_class_ro) else $error("class code read wrong");

	property p_maker_ro;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		CE_IN && rif.rd && rif.addr == OFS_MAKER_HI |=> rif.rdata == MAKER_CODE[FREQ_W-1:DATA_W];
	endproperty
	a_maker_ro: assert property (p_maker_ro) else $error("maker code read wrong");

	property p_freq_write;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		CE_IN && rif.wr && rif.addr == OFS_FREQ_LO |=> CONV_CLK_FREQ_OUT[DATA_W-1:0] == $past(rif.wdata);
	endproperty
	a_freq_write: assert property (p_freq_write) else $error("frequency low byte lost");

	property p_byte_commit;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		rif.wr |-> state == ST_DONE && !is_read && !rif.rd;
	endproperty
	a_byte_commit: assert property (p_byte_commit) else $error("write outside byte end");
endmodule

// [verilog/cirb_pin_sync.sv]
// Two-stage synchroniser for the serial port pins
`timescale 1ns/1ns
module cirb_pin_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             ce_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta; // First stage, read only by the second

	////////////////////////////////////////////////////////////////////////////
	// One pair of flops per pin
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			// Pins are asynchronous to the clock
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					meta[g]     <= RST_VAL[g];
					sync_out[g] <= RST_VAL[g];
				end else if (ce_in) begin
					meta[g]     <= async_in[g];
					sync_out[g] <= meta[g];
				end
			end
		end
	endgenerate
endmodule

// [verilog/cirb_pkg.sv]
// Package: register map, reset values and serial frame constants of the config bank
package cirb_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int ADDR_W  = 10; // Register offset width
	localparam int DATA_W  = 8;  // Register width
	localparam int INSTR_W = 16; // Instruction word width
	localparam int FREQ_W  = 16; // Converter clock setting width
	localparam int PWR_W   = 2;  // Power state field width
	localparam int CNT_W   = 4;  // Bit counter width
	localparam int SLOT_W  = 4;  // Storage slot index width
	localparam int RW_BIT  = 15; // Read flag position in the instruction

	localparam logic [CNT_W-1:0] INSTR_LAST = 4'hF; // Last instruction bit
	localparam logic [CNT_W-1:0] DATA_LAST  = 4'h7; // Last data bit

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_FORMAT    = 10'h000;
	localparam logic [ADDR_W-1:0] OFS_POWER     = 10'h002;
	localparam logic [ADDR_W-1:0] OFS_CLASS     = 10'h003;
	localparam logic [ADDR_W-1:0] OFS_CODE_LO   = 10'h004;
	localparam logic [ADDR_W-1:0] OFS_CODE_HI   = 10'h005;
	localparam logic [ADDR_W-1:0] OFS_GRADE     = 10'h006;
	localparam logic [ADDR_W-1:0] OFS_MAKER_LO  = 10'h00C;
	localparam logic [ADDR_W-1:0] OFS_MAKER_HI  = 10'h00D;
	localparam logic [ADDR_W-1:0] OFS_FREQ_LO   = 10'h100;
	localparam logic [ADDR_W-1:0] OFS_FREQ_HI   = 10'h101;
	localparam logic [ADDR_W-1:0] OFS_OSC_CAL_R = 10'h2A5;
	localparam logic [ADDR_W-1:0] OFS_OSC_BIAS  = 10'h2AA;
	localparam logic [ADDR_W-1:0] OFS_OSC_CAL   = 10'h2AB;
	localparam logic [ADDR_W-1:0] OFS_CP_CUR    = 10'h2AC;
	localparam logic [ADDR_W-1:0] OFS_CP_CAL_EN = 10'h2AD;
	localparam logic [ADDR_W-1:0] OFS_OSC_VAR   = 10'h2B7;
	localparam logic [ADDR_W-1:0] OFS_REF_DIV   = 10'h2BB;
	localparam logic [ADDR_W-1:0] OFS_SYN_STAT  = 10'h2BC;
	localparam logic [ADDR_W-1:0] OFS_LINK_STAT = 10'h2DC;
	localparam logic [ADDR_W-1:0] OFS_SHUF_CTRL = 10'h340;
	localparam logic [ADDR_W-1:0] OFS_SHUF_TH_A = 10'h342;
	localparam logic [ADDR_W-1:0] OFS_SHUF_TH_B = 10'h343;

	////////////////////////////////////////////////////////////////////////////
	// Format register fields and fixed values
	localparam int FMT_RST_HI = 7;
	localparam int FMT_LSB_HI = 6;
	localparam int FMT_4W_HI  = 4;
	localparam int FMT_4W_LO  = 3;
	localparam int FMT_LSB_LO = 1;
	localparam int FMT_RST_LO = 0;
	localparam logic [DATA_W-1:0] FMT_RESET  = 8'h18;
	localparam logic [DATA_W-1:0] STAT_RESET = 8'h80;
	localparam logic [DATA_W-1:0] TH_B_RESET = 8'h00;
	localparam logic [2:0]        SYNC_RESET = 3'h2; // Chip select idles high

	// Power state field codes
	typedef enum logic [PWR_W-1:0] {
		PWR_NORMAL  = 2'h0,
		PWR_UNUSED  = 2'h1,
		PWR_STANDBY = 2'h2,
		PWR_SLEEP   = 2'h3
	} cirb_pwr_e;

	////////////////////////////////////////////////////////////////////////////
	// Writable storage slots
	localparam int NUM_SLOTS = 13;
	localparam logic [SLOT_W-1:0] SLOT_POWER   = 4'h0;
	localparam logic [SLOT_W-1:0] SLOT_FREQ_LO = 4'h1;
	localparam logic [SLOT_W-1:0] SLOT_FREQ_HI = 4'h2;
	localparam logic [ADDR_W-1:0] SLOT_ADDR [NUM_SLOTS] = '{OFS_POWER, OFS_FREQ_LO, OFS_FREQ_HI,
		OFS_OSC_CAL_R, OFS_OSC_BIAS, OFS_OSC_CAL, OFS_CP_CUR, OFS_CP_CAL_EN, OFS_OSC_VAR,
		OFS_REF_DIV, OFS_SHUF_CTRL, OFS_SHUF_TH_A, OFS_SHUF_TH_B};
	localparam logic [DATA_W-1:0] SLOT_RST [NUM_SLOTS] = '{8'h00, 8'h10, 8'h0E, 8'h00, 8'h37,
		8'hC0, 8'h19, 8'h00, 8'hD0, 8'hB9, 8'h03, 8'hF5, TH_B_RESET};
	localparam logic [DATA_W-1:0] SLOT_MASK [NUM_SLOTS] = '{8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

endpackage

// [verilog/cirb_reg_file.sv]
// Register storage, read mux and soft reset of the config bank
`timescale 1ns/1ns
module cirb_reg_file
	import cirb_pkg::*;
#(
	parameter logic [DATA_W-1:0] DEV_CLASS = 8'h5A,    // Arbitrary value
	parameter logic [FREQ_W-1:0] DEV_CODE  = 16'h1234, // Arbitrary value
	parameter logic [3:0]        REVISION  = 4'h2,     // Arbitrary value
	parameter logic [3:0]        GRADE     = 4'h1,     // Arbitrary value
	parameter logic [FREQ_W-1:0] MAKER     = 16'h7E9C  // Arbitrary value
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	cirb_reg_if.regs  rif
);
	logic [DATA_W-1:0] mem      [NUM_SLOTS]; // Writable bytes
	logic [DATA_W-1:0] next_mem [NUM_SLOTS];
	logic              lsb_first;            // Bit order
	logic              next_lsb_first;
	logic              four_wire;            // Output pin select
	logic              next_four_wire;
	logic [DATA_W-1:0] rdata;                // Registered read byte
	logic [DATA_W-1:0] next_rdata;
	cirb_pwr_e         power;                // Effective power state
	cirb_pwr_e         next_power;
	logic [SLOT_W:0]   hit;                  // Slot match and index
	logic [DATA_W-1:0] fmt;                  // Format byte as read
	logic              soft_rst;             // Soft reset request

	// Offset to storage slot, used by read and write
	function automatic logic [SLOT_W:0] slot_of(input logic [ADDR_W-1:0] a);
		slot_of = '0;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			if (SLOT_ADDR[i] == a) begin
				slot_of = {1'b1, SLOT_W'(i)};
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state of the storage
	always_comb begin
		hit            = slot_of(rif.addr);
		next_mem       = mem;
		next_lsb_first = lsb_first;
		next_four_wire = four_wire;
		next_rdata     = rdata;
		fmt             = '0;
		fmt[FMT_LSB_HI] = lsb_first;
		fmt[FMT_LSB_LO] = lsb_first;
		fmt[FMT_4W_HI]  = four_wire;
		fmt[FMT_4W_LO]  = four_wire;
		// Either mirror of the reset bit triggers it
		soft_rst = rif.wr && rif.addr == OFS_FORMAT && (rif.wdata[FMT_RST_HI] || rif.wdata[FMT_RST_LO]);
		if (rif.rd) begin
			case (rif.addr)
				OFS_FORMAT:    next_rdata = fmt;
				OFS_CLASS:     next_rdata = DEV_CLASS;
				OFS_CODE_LO:   next_rdata = DEV_CODE[DATA_W-1:0];
				OFS_CODE_HI:   next_rdata = DEV_CODE[FREQ_W-1:DATA_W];
				OFS_GRADE:     next_rdata = {REVISION, GRADE};
				OFS_MAKER_LO:  next_rdata = MAKER[DATA_W-1:0];
				OFS_MAKER_HI:  next_rdata = MAKER[FREQ_W-1:DATA_W];
				OFS_SYN_STAT:  next_rdata = STAT_RESET;
				OFS_LINK_STAT: next_rdata = STAT_RESET;
				default:       next_rdata = hit[SLOT_W] ? mem[hit[SLOT_W-1:0]] : '0;
			endcase
		end
		if (soft_rst) begin
			next_mem       = SLOT_RST;
			next_lsb_first = FMT_RESET[FMT_LSB_HI];
			next_four_wire = FMT_RESET[FMT_4W_HI];
		end else if (rif.wr) begin
			if (rif.addr == OFS_FORMAT) begin
				next_lsb_first = rif.wdata[FMT_LSB_HI] || rif.wdata[FMT_LSB_LO];
				next_four_wire = rif.wdata[FMT_4W_HI] || rif.wdata[FMT_4W_LO];
			end else if (hit[SLOT_W]) begin
				next_mem[hit[SLOT_W-1:0]] = rif.wdata & SLOT_MASK[hit[SLOT_W-1:0]];
			end
		end
		next_power = cirb_pwr_e'(next_mem[SLOT_POWER][PWR_W-1:0]);
		if (next_power == PWR_UNUSED) begin
			next_power = PWR_NORMAL;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Storage flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem       <= SLOT_RST;
			lsb_first <= FMT_RESET[FMT_LSB_HI];
			four_wire <= FMT_RESET[FMT_4W_HI];
			rdata     <= '0;
			power     <= PWR_NORMAL;
		end else if (ce_in) begin
			mem       <= next_mem;
			lsb_first <= next_lsb_first;
			four_wire <= next_four_wire;
			rdata     <= next_rdata;
			power     <= next_power;
		end
	end

	assign rif.rdata      = rdata;
	assign rif.lsb_first  = lsb_first;
	assign rif.four_wire  = four_wire;
	assign rif.power_mode = power;
	assign rif.conv_freq  = {mem[SLOT_FREQ_HI], mem[SLOT_FREQ_LO]};

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_soft_reset;
		@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && rif.wr && rif.addr == OFS_FORMAT && (rif.wdata[FMT_RST_HI] || rif.wdata[FMT_RST_LO])
		|=> rif.conv_freq == {SLOT_RST[SLOT_FREQ_HI], SLOT_RST[SLOT_FREQ_LO]} && rif.four_wire && !rif.lsb_first;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a non-default");

	property p_sleep_mode;
		@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && rif.wr && rif.addr == OFS_POWER && rif.wdata[PWR_W-1:0] == PWR_SLEEP
		|=> rif.power_mode == PWR_SLEEP ##1 rif.power_mode != PWR_UNUSED;
	endproperty
	a_sleep_mode: assert property (p_sleep_mode) else $error("power state not taken");

	// Unused code is stored but must run as normal operation
	property p_unused_code;
		@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && rif.wr && rif.addr == OFS_POWER && rif.wdata[PWR_W-1:0] == PWR_UNUSED
		|=> rif.power_mode == PWR_NORMAL;
	endproperty
	a_unused_code: assert property (p_unused_code) else $error("unused power code not normal");
endmodule

// [verilog/cirb_reg_if.sv]
// Interface: carrier between the serial port engine and the register storage
`timescale 1ns/1ns
interface cirb_reg_if;
	logic                           wr;         // One-cycle write strobe
	logic                           rd;         // One-cycle read strobe
	logic [cirb_pkg::ADDR_W-1:0]    addr;       // Register offset
	logic [cirb_pkg::DATA_W-1:0]    wdata;      // Write byte
	logic [cirb_pkg::DATA_W-1:0]    rdata;      // Read byte, valid after rd
	logic                           lsb_first;  // Bit order setting
	logic                           four_wire;  // Separate output pin setting
	cirb_pkg::cirb_pwr_e            power_mode; // Effective power state
	logic [cirb_pkg::FREQ_W-1:0]    conv_freq;  // Converter clock setting

	// Engine side
	modport port (output wr, rd, addr, wdata,
		input rdata, lsb_first, four_wire, power_mode, conv_freq);
	// Storage side
	modport regs (input wr, rd, addr, wdata,
		output rdata, lsb_first, four_wire, power_mode, conv_freq);
endinterface
